// ===== design/data_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module data_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [$clog2(DEPTH):0] count_out
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic full;
		logic empty;
		logic room;
		logic [WIDTH-1:0] dout;
	} fifo_st_t;

	fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	always_comb begin
		s_d = s_q;
		push = in_valid_in & ~s_q.full;
		pop = out_ready_in & ~s_q.empty;
		s_d.wp = s_q.wp + AW'(push);
		s_d.rp = s_q.rp + AW'(pop);
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		s_d.full = (s_d.cnt == (AW+1)'(DEPTH));
		s_d.empty = (s_d.cnt == '0);
		s_d.room = ~s_d.full;
		// Head word is registered; bypass when writing the slot about to be read
		s_d.dout = (push && s_q.wp == s_d.rp) ? in_data_in : mem[s_d.rp];
	end

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[s_q.wp] <= in_data_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_q <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1, room: 1'b1, dout: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign in_ready_out = s_q.room;
	assign out_valid_out = ~s_q.empty;
	assign out_data_out = s_q.dout;
	assign count_out = s_q.cnt;
endmodule : data_fifo
`default_nettype wire

// ===== design/mb_master_cfg.svh
`ifndef MB_MASTER_CFG_SVH
`define MB_MASTER_CFG_SVH

// Clock and link timing
`define CLK_HZ 20000000
`define BAUD_RATE 9600
`define CHAR_BITS 11
// Gaps in half character times
`define FRAME_GAP_HALF 8'h07
`define BYTE_GAP_HALF 8'h03
`define RSP_TIMEOUT_HALF 8'hC8

// Function codes
`define FN_READ 8'h03
`define FN_WRITE_ONE 8'h06
`define FN_WRITE_MANY 8'h10
`define FN_EXC_BIT 7
`define MAX_WORDS 16'h0010

// Frame layout
`define REQ_LEN_SHORT 6'h06
`define REQ_LEN_MANY 6'h07
`define RSP_MIN_BYTES 6'h03
`define RSP_DATA_FIRST 6'h03

// ASCII framing
`define CHR_START 8'h3A
`define CHR_CR 8'h0D
`define CHR_LF 8'h0A
`define CHR_DIGIT0 8'h30
`define CHR_DIGIT9 8'h39
`define CHR_UPPER_A 8'h41
`define CHR_UPPER_F 8'h46
`define CHR_LETTER_BASE 8'h37

// Checksums
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define LRC_INIT 8'h00

`endif

// ===== design/mb_master_pkg.sv
package mb_master_pkg;

	typedef enum logic [2:0] {PH_IDLE, PH_GAP, PH_TX, PH_DRAIN, PH_RX} phase_t;

	typedef struct packed {
		logic ascii;
		logic [7:0] station;
		logic [7:0] func;
		logic [15:0] start;
		logic [15:0] count;
	} cmd_t;

	typedef struct packed {
		logic timeout;
		logic bad_cmd;
		logic ok;
		logic exc;
		logic [7:0] code;
		logic [4:0] words;
	} rsp_t;

	typedef struct packed {
		phase_t ph;
		cmd_t cmd;
		logic [15:0] div;
		logic [7:0] gap;
		logic [1:0] tpos;
		logic nib;
		logic [5:0] tidx;
		logic [15:0] crc;
		logic [7:0] lrc;
		logic txv;
		logic [7:0] txb;
		logic de;
		logic rdy;
		logic [5:0] ridx;
		logic rnib;
		logic [3:0] rhi;
		logic rbad;
		logic [7:0] rbc;
		logic [7:0] rhb;
		logic [15:0] rw;
		logic rwv;
		rsp_t rsp;
		logic rspv;
	} master_st_t;

endpackage : mb_master_pkg

// ===== design/modbus_master.sv
// Function
// - Frames are separated by idle longer than 3.5 characters; that idle ends a frame.
// - Inside a frame, gaps between bytes stay at most 1.5 characters.
// - ASCII frame: colon, address, function, data, LRC, CR LF.
// - ASCII bytes go as two hex characters, high nibble first, 0-9 and A-F.
// - Fractions travel as scaled hex integers, 0.10 as 0x0A.
// - Read request: address, function, start address and count up to 16, high first.
// - RTU CRC goes low byte first, then high byte.
// - Multiple write 0x10: start, count up to 16, byte count, values.
// - ASCII function code is two characters, like 0x30 0x33.
// - ASCII start address and count take four characters, LRC two.
// - Half-duplex shared link; slaves transmit only when answering.
// - CRC LSB first, init 0xffff, reflected polynomial 0xa001.
// - LRC is two's complement of the carry-free byte sum, address to data.
`timescale 1ns/10ps
`default_nettype none
`include "mb_master_cfg.svh"
module modbus_master
	import mb_master_pkg::*;
#(
	parameter int HALF_CHAR_CYC = `CLK_HZ * `CHAR_BITS / (2 * `BAUD_RATE)
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire cmd_t cmd_in,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic [15:0] wr_word_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [15:0] rd_word_out,
	output logic rd_valid_out,
	output rsp_t rsp_out,
	output logic rsp_valid_out,
	output logic [7:0] tx_byte_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	output logic drv_en_out,
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_valid_in
);
	master_st_t s_q, s_d;
	logic [15:0] fifo_word;
	logic fifo_pop;
	logic [4:0] fifo_cnt;

	data_fifo #(.WIDTH(16), .DEPTH(16)) u_fifo (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.in_data_in(wr_word_in),
		.in_valid_in(wr_valid_in),
		.in_ready_out(wr_ready_out),
		.out_data_out(fifo_word),
		.out_valid_out(),
		.out_ready_in(fifo_pop),
		.count_out(fifo_cnt)
	);

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	function automatic logic [7:0] hex_chr(input logic [3:0] v);
		return (v < 4'hA) ? (`CHR_DIGIT0 + {4'h0, v}) : (`CHR_LETTER_BASE + {4'h0, v});
	endfunction : hex_chr

	logic [5:0] len;
	logic [7:0] bt;
	logic [4:0] need;
	logic half, take, is_hex, word_lo;
	logic [7:0] rb;
	logic [3:0] rnv;

	// Request byte at the current transmit index
	always_comb begin
		if (s_q.cmd.func == `FN_WRITE_MANY) begin
			len = `REQ_LEN_MANY + {s_q.cmd.count[4:0], 1'b0};
		end else begin
			len = `REQ_LEN_SHORT;
		end
		unique case (s_q.tidx)
			6'h00: bt = s_q.cmd.station;
			6'h01: bt = s_q.cmd.func;
			6'h02: bt = s_q.cmd.start[15:8];
			6'h03: bt = s_q.cmd.start[7:0];
			6'h04: bt = (s_q.cmd.func == `FN_WRITE_ONE) ? fifo_word[15:8] : s_q.cmd.count[15:8];
			6'h05: bt = (s_q.cmd.func == `FN_WRITE_ONE) ? fifo_word[7:0] : s_q.cmd.count[7:0];
			6'h06: bt = {s_q.cmd.count[6:0], 1'b0};
			default: bt = s_q.tidx[0] ? fifo_word[15:8] : fifo_word[7:0];
		endcase
		if (s_q.tidx == len) begin
			bt = s_q.cmd.ascii ? (~s_q.lrc + 8'h01) : s_q.crc[7:0];
		end else if (s_q.tidx == len + 6'h01) begin
			bt = s_q.crc[15:8];
		end
		// Release a write word only once its low byte has gone out
		word_lo = (s_q.cmd.func == `FN_WRITE_ONE) ? (s_q.tidx == 6'h05) :
			(s_q.cmd.func == `FN_WRITE_MANY && s_q.tidx >= 6'h08 && !s_q.tidx[0]);
		unique case (s_q.cmd.func)
			`FN_WRITE_ONE: need = 5'h01;
			`FN_WRITE_MANY: need = s_q.cmd.count[4:0];
			default: need = 5'h00;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.rwv = 1'b0;
		s_d.rspv = 1'b0;
		fifo_pop = 1'b0;
		take = 1'b0;
		rb = rx_byte_in;
		is_hex = (rx_byte_in >= `CHR_DIGIT0 && rx_byte_in <= `CHR_DIGIT9) ||
			(rx_byte_in >= `CHR_UPPER_A && rx_byte_in <= `CHR_UPPER_F);
		rnv = (rx_byte_in <= `CHR_DIGIT9) ? rx_byte_in[3:0] : 4'(rx_byte_in - `CHR_LETTER_BASE);
		half = (s_q.div == 16'(HALF_CHAR_CYC - 1));
		s_d.div = half ? 16'h0000 : s_q.div + 16'h0001;
		if (rx_valid_in) begin
			s_d.gap = 8'h00;
		end else if (half && s_q.gap != 8'hFF) begin
			s_d.gap = s_q.gap + 8'h01;
		end
		unique case (s_q.ph)
			PH_IDLE: begin
				if (cmd_valid_in && s_q.rdy) begin
					s_d.cmd = cmd_in;
					if ((cmd_in.func != `FN_READ && cmd_in.func != `FN_WRITE_ONE && cmd_in.func != `FN_WRITE_MANY) ||
						(cmd_in.func != `FN_WRITE_ONE && (cmd_in.count == 16'h0000 || cmd_in.count > `MAX_WORDS))) begin
						s_d.rsp = '{timeout: 1'b0, bad_cmd: 1'b1, ok: 1'b0, exc: 1'b0, code: 8'h00, words: 5'h00};
						s_d.rspv = 1'b1;
					end else begin
						s_d.rdy = 1'b0;
						s_d.ph = PH_GAP;
					end
				end
			end
			PH_GAP: begin
				// Speak only after a full frame gap and with every write word queued
				if (s_q.gap >= `FRAME_GAP_HALF && fifo_cnt >= need) begin
					s_d.ph = PH_TX;
					s_d.de = 1'b1;
					s_d.tidx = 6'h00;
					s_d.nib = 1'b0;
					s_d.tpos = s_q.cmd.ascii ? 2'h0 : 2'h1;
					s_d.crc = `CRC_INIT;
					s_d.lrc = `LRC_INIT;
				end
			end
			PH_TX: begin
				if (!s_q.txv || tx_ready_in) begin
					s_d.txv = 1'b1;
					if (s_q.cmd.ascii) begin
						unique case (s_q.tpos)
							2'h0: begin
								s_d.txb = `CHR_START;
								s_d.tpos = 2'h1;
							end
							2'h1: begin
								s_d.txb = hex_chr(s_q.nib ? bt[3:0] : bt[7:4]);
								s_d.nib = ~s_q.nib;
								if (s_q.nib) begin
									s_d.tidx = s_q.tidx + 6'h01;
									if (s_q.tidx < len) begin
										s_d.lrc = s_q.lrc + bt;
										fifo_pop = word_lo;
									end else begin
										s_d.tpos = 2'h2;
									end
								end
							end
							2'h2: begin
								s_d.txb = `CHR_CR;
								s_d.tpos = 2'h3;
							end
							2'h3: begin
								s_d.txb = `CHR_LF;
								s_d.ph = PH_DRAIN;
							end
						endcase
					end else begin
						s_d.txb = bt;
						s_d.tidx = s_q.tidx + 6'h01;
						if (s_q.tidx < len) begin
							s_d.crc = crc_step(s_q.crc, bt);
							fifo_pop = word_lo;
						end else if (s_q.tidx == len + 6'h01) begin
							s_d.ph = PH_DRAIN;
						end
					end
				end
			end
			PH_DRAIN: begin
				if (tx_ready_in) begin
					s_d.txv = 1'b0;
					s_d.de = 1'b0;
					s_d.ph = PH_RX;
					s_d.gap = 8'h00;
					s_d.ridx = 6'h00;
					s_d.rnib = 1'b0;
					s_d.rbad = 1'b0;
					s_d.crc = `CRC_INIT;
					s_d.lrc = `LRC_INIT;
					s_d.rsp = '0;
				end
			end
			PH_RX: begin
				if (rx_valid_in) begin
					if (s_q.cmd.ascii) begin
						if (rx_byte_in == `CHR_START) begin
							s_d.ridx = 6'h00;
							s_d.rnib = 1'b0;
							s_d.rbad = 1'b0;
							s_d.lrc = `LRC_INIT;
							s_d.rsp = '0;
						end else if (is_hex) begin
							s_d.rnib = ~s_q.rnib;
							s_d.rhi = rnv;
							take = s_q.rnib;
							rb = {s_q.rhi, rnv};
						end else if (rx_byte_in != `CHR_CR && rx_byte_in != `CHR_LF) begin
							s_d.rbad = 1'b1;
						end
					end else begin
						take = 1'b1;
						if (s_q.ridx != 6'h00 && s_q.gap >= `BYTE_GAP_HALF) begin
							s_d.rbad = 1'b1;
						end
					end
				end
				if (take) begin
					s_d.ridx = (s_q.ridx == 6'h3F) ? s_q.ridx : s_q.ridx + 6'h01;
					s_d.crc = crc_step(s_q.crc, rb);
					s_d.lrc = s_q.lrc + rb;
					if (s_q.ridx == 6'h00 && rb != s_q.cmd.station) begin
						s_d.rbad = 1'b1;
					end
					if (s_q.ridx == 6'h01) begin
						s_d.rsp.exc = rb[`FN_EXC_BIT];
						if (rb[6:0] != s_q.cmd.func[6:0]) begin
							s_d.rbad = 1'b1;
						end
					end
					if (s_q.ridx == 6'h02) begin
						s_d.rbc = rb;
						s_d.rsp.code = s_q.rsp.exc ? rb : 8'h00;
						if (!s_q.rsp.exc && s_q.cmd.func == `FN_READ && rb != {s_q.cmd.count[6:0], 1'b0}) begin
							s_d.rbad = 1'b1;
						end
					end
					if (!s_q.rsp.exc && s_q.cmd.func == `FN_READ && s_q.ridx >= `RSP_DATA_FIRST &&
						s_q.ridx < `RSP_DATA_FIRST + s_q.rbc[5:0]) begin
						if (s_q.ridx[0]) begin
							s_d.rhb = rb;
						end else begin
							s_d.rw = {s_q.rhb, rb};
							s_d.rwv = 1'b1;
							s_d.rsp.words = s_q.rsp.words + 5'h01;
						end
					end
				end
				// End of reply: LF in ASCII, frame gap in RTU; checksums fold to zero over the whole frame
				if ((s_q.cmd.ascii && rx_valid_in && rx_byte_in == `CHR_LF) ||
					(!s_q.cmd.ascii && !rx_valid_in && s_q.ridx != 6'h00 && s_q.gap >= `FRAME_GAP_HALF)) begin
					s_d.rsp.ok = !s_q.rbad && s_q.ridx >= `RSP_MIN_BYTES &&
						(s_q.cmd.ascii ? (s_q.lrc == 8'h00) : (s_q.crc == 16'h0000));
					s_d.rspv = 1'b1;
					s_d.rdy = 1'b1;
					s_d.ph = PH_IDLE;
				end else if (s_q.ridx == 6'h00 && !rx_valid_in && s_q.gap >= `RSP_TIMEOUT_HALF) begin
					s_d.rsp.timeout = 1'b1;
					s_d.rspv = 1'b1;
					s_d.rdy = 1'b1;
					s_d.ph = PH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_q <= '0;
			s_q.ph <= PH_IDLE;
			s_q.rdy <= 1'b1;
			s_q.crc <= `CRC_INIT;
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_ready_out = s_q.rdy;
	assign rd_word_out = s_q.rw;
	assign rd_valid_out = s_q.rwv;
	assign rsp_out = s_q.rsp;
	assign rsp_valid_out = s_q.rspv;
	assign tx_byte_out = s_q.txb;
	assign tx_valid_out = s_q.txv;
	assign drv_en_out = s_q.de;
endmodule : modbus_master
`default_nettype wire

// ===== verification/modbus_master_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_master_monitor
	import mb_master_pkg::*;
#(
	parameter int HALF_CHAR_CYC = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire cmd_t cmd_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_ready_out,
	input wire rsp_t rsp_out,
	input wire logic rsp_valid_out,
	input wire logic [7:0] tx_byte_out,
	input wire logic tx_valid_out,
	input wire logic tx_ready_in,
	input wire logic drv_en_out,
	input wire logic rx_valid_in
);
	logic ascii_q;
	logic [7:0] stn_q;
	int idle_q;
	logic bad_c;
	assign bad_c = !(cmd_in.func inside {8'h03, 8'h06, 8'h10})
		|| (cmd_in.func != 8'h06 && (cmd_in.count == 16'h0000 || cmd_in.count > 16'h0010));
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ascii_q <= 1'b0;
			stn_q <= 8'h00;
			idle_q <= 0;
		end else begin
			if (cmd_valid_in && cmd_ready_out) begin
				ascii_q <= cmd_in.ascii;
				stn_q <= cmd_in.station;
			end
			idle_q <= (drv_en_out || rx_valid_in) ? 0 : idle_q + 1;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_take;
		cmd_valid_in && cmd_ready_out;
	endsequence
	sequence s_start;
		$rose(drv_en_out) ##1 tx_valid_out;
	endsequence
	a_frame_gap: assert property ($rose(drv_en_out) |-> idle_q >= 6 * HALF_CHAR_CYC)
		else $error("frame started early");
	a_drv_lead: assert property ($rose(drv_en_out) |=> tx_valid_out)
		else $error("no byte after driver on");
	a_first_byte: assert property (s_start |-> tx_byte_out == (ascii_q ? 8'h3A : stn_q))
		else $error("wrong first byte");
	a_hex_chars: assert property (tx_valid_out && ascii_q |-> tx_byte_out inside
		{8'h3A, 8'h0D, 8'h0A, [8'h30:8'h39], [8'h41:8'h46]})
		else $error("bad ascii char");
	a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
		else $error("byte changed while waiting");
	a_no_stall: assert property (tx_valid_out && tx_ready_in |=> tx_valid_out or ##[0:1] !drv_en_out)
		else $error("gap inside frame");
	a_drv_cover: assert property (tx_valid_out |-> drv_en_out)
		else $error("byte without driver");
	a_idle_quiet: assert property (cmd_ready_out |-> !drv_en_out)
		else $error("driver on while idle");
	a_refuse_cmd: assert property (s_take ##0 bad_c |-> ##[1:2] rsp_valid_out && rsp_out.bad_cmd)
		else $error("bad command not refused");
	a_reply_ready: assert property (rsp_valid_out |-> ##[0:1] cmd_ready_out)
		else $error("not idle after answer");
endmodule : modbus_master_monitor

bind modbus_master modbus_master_monitor #(.HALF_CHAR_CYC(HALF_CHAR_CYC)) u_mon (.core_clk_in, .rst_b_in,
	.cmd_in, .cmd_valid_in, .cmd_ready_out, .rsp_out, .rsp_valid_out, .tx_byte_out, .tx_valid_out,
	.tx_ready_in, .drv_en_out, .rx_valid_in);
`default_nettype wire

// ===== verification/modbus_master_tb.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_master_tb
	import mb_master_pkg::*;
;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	cmd_t cmd_in = '0;
	logic cmd_valid_in = 1'b0;
	logic cmd_ready_out;
	logic [15:0] wr_word_in = 16'h0000;
	logic wr_valid_in = 1'b0;
	logic wr_ready_out;
	logic [15:0] rd_word_out;
	logic rd_valid_out;
	rsp_t rsp_out;
	logic rsp_valid_out;
	logic [7:0] tx_byte_out;
	logic tx_valid_out;
	logic tx_ready_in;
	logic drv_en_out;
	logic [7:0] rx_byte_in;
	logic rx_valid_in;
	logic slow = 1'b0;
	logic [1:0] fault = 2'd0;
	logic ascii_cfg = 1'b0;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [7:0] tx_q[$];
	logic [15:0] rd_q[$];
	modbus_master #(.HALF_CHAR_CYC(4)) u_dut (.core_clk_in, .rst_b_in, .cmd_in, .cmd_valid_in, .cmd_ready_out,
		.wr_word_in, .wr_valid_in, .wr_ready_out, .rd_word_out, .rd_valid_out, .rsp_out, .rsp_valid_out,
		.tx_byte_out, .tx_valid_out, .tx_ready_in, .drv_en_out, .rx_byte_in, .rx_valid_in);
	modbus_slave_model #(.HC(4)) u_slave (.core_clk_in, .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
		.tx_ready_out(tx_ready_in), .drv_en_in(drv_en_out), .rx_byte_out(rx_byte_in), .rx_valid_out(rx_valid_in),
		.ascii_in(ascii_cfg), .slow_in(slow), .fault_in(fault));
	always #25 core_clk_in = ~core_clk_in;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (tx_valid_out && tx_ready_in)
			tx_q.push_back(tx_byte_out);
		if (rd_valid_out)
			rd_q.push_back(rd_word_out);
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cmp_q(input string what, input int n, input logic [7:0] exp[$]);
		check(what, 16'(tx_q.size()), 16'(n));
		foreach (exp[i])
			check(what, {8'h00, tx_q[i]}, {8'h00, exp[i]});
	endtask : cmp_q
	task automatic push(input logic [15:0] w);
		@(negedge core_clk_in);
		wr_word_in = w;
		wr_valid_in = 1'b1;
		do @(posedge core_clk_in); while (wr_ready_out !== 1'b1);
		@(negedge core_clk_in);
		wr_valid_in = 1'b0;
	endtask : push
	task automatic run(input logic a, input logic [7:0] st, input logic [7:0] fn, input logic [15:0] sa,
		input logic [15:0] n);
		tx_q.delete();
		rd_q.delete();
		@(negedge core_clk_in);
		ascii_cfg = a;
		cmd_in = '{a, st, fn, sa, n};
		cmd_valid_in = 1'b1;
		do @(posedge core_clk_in); while (cmd_ready_out !== 1'b1);
		@(negedge core_clk_in);
		cmd_valid_in = 1'b0;
		do @(posedge core_clk_in); while (rsp_valid_out !== 1'b1);
	endtask : run
	task automatic t_reads();
		run(1'b0, 8'h01, 8'h03, 16'h0004, 16'h0002);
		cmp_q("read req", 8, '{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hCA});
		check("word0", rd_q[0], 16'h0004);
		check("word1", rd_q[1], 16'h0005);
		check("ok", 16'(rsp_out.ok), 16'h0001);
		slow = 1'b1;
		run(1'b0, 8'h01, 8'h03, 16'h0100, 16'h0010);
		slow = 1'b0;
		for (int i = 0; i < 16; i++)
			check("word", rd_q[i], 16'h0100 + 16'(i));
		check("words", 16'(rsp_out.words), 16'h0010);
		$display("reads done");
	endtask : t_reads
	task automatic t_writes();
		push(16'h0064);
		run(1'b0, 8'h01, 8'h06, 16'h0200, 16'h0001);
		cmp_q("write req", 8, '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64, 8'h89, 8'h99});
		check("echo ok", 16'(rsp_out.ok), 16'h0001);
		push(16'h1234);
		push(16'h5678);
		run(1'b0, 8'h01, 8'h10, 16'h0010, 16'h0002);
		cmp_q("multi req", 13, '{8'h01, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78});
		check("multi ok", 16'(rsp_out.ok), 16'h0001);
		push(16'h0064);
		run(1'b1, 8'h01, 8'h06, 16'h0200, 16'h0001);
		cmp_q("ascii req", 17, '{8'h3A, 8'h30, 8'h31, 8'h30, 8'h36, 8'h30, 8'h32, 8'h30, 8'h30, 8'h30, 8'h30,
			8'h36, 8'h34, 8'h39, 8'h33, 8'h0D, 8'h0A});
		check("ascii ok", 16'(rsp_out.ok), 16'h0001);
		$display("writes done");
	endtask : t_writes
	task automatic t_faults();
		logic [7:0] fn[4] = '{8'h05, 8'h03, 8'h03, 8'h10};
		logic [15:0] cn[4] = '{16'h0001, 16'h0000, 16'h0011, 16'h0011};
		foreach (fn[i]) begin
			run(1'b0, 8'h01, fn[i], 16'h0000, cn[i]);
			check("refused", 16'(rsp_out.bad_cmd), 16'h0001);
			check("sent", 16'(tx_q.size()), 16'h0000);
		end
		fault = 2'd1;
		run(1'b0, 8'h01, 8'h03, 16'h0000, 16'h0001);
		check("exc", 16'(rsp_out.exc), 16'h0001);
		check("code", 16'(rsp_out.code), 16'h0004);
		fault = 2'd2;
		run(1'b0, 8'h01, 8'h03, 16'h0000, 16'h0001);
		check("gap ok", 16'(rsp_out.ok), 16'h0000);
		fault = 2'd0;
		run(1'b0, 8'h02, 8'h03, 16'h0000, 16'h0001);
		check("timeout", 16'(rsp_out.timeout), 16'h0001);
		$display("faults done");
	endtask : t_faults
	initial begin
		repeat (12) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		t_reads();
		t_writes();
		t_faults();
		report_and_stop();
	end
endmodule : modbus_master_tb
`default_nettype wire

// ===== verification/modbus_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_slave_model #(
	parameter logic [7:0] MY_STATION = 8'h01,
	parameter int HC = 4
) (
	input wire logic core_clk_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	input wire logic drv_en_in,
	output logic [7:0] rx_byte_out,
	output logic rx_valid_out,
	input wire logic ascii_in,
	input wire logic slow_in,
	input wire logic [1:0] fault_in
);
	logic [7:0] req[$];
	logic [7:0] rsp[$];
	logic drv_q = 1'b0;
	logic [15:0] c;
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] r;
		r = 16'hFFFF;
		foreach (b[i]) begin
			r = r ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
		end
		return r;
	endfunction : crc16
	always @(negedge core_clk_in)
		tx_ready_out <= !slow_in || !tx_ready_out;
	always @(posedge core_clk_in) begin
		if (tx_valid_in && tx_ready_out)
			req.push_back(tx_byte_in);
		drv_q <= drv_en_in;
	end
	initial begin
		tx_ready_out = 1'b1;
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h00;
		forever begin
			@(negedge core_clk_in);
			if (drv_q && !drv_en_in) begin
				rsp.delete();
				if (ascii_in)
					rsp = req;
				else if (req[0] == MY_STATION && crc16(req) == 16'h0000) begin
					rsp = req[0:5];
					if (fault_in == 2'd1)
						rsp = '{req[0], req[1] | 8'h80, 8'h04};
					else if (req[1] == 8'h03) begin
						rsp = '{req[0], req[1], {req[5][6:0], 1'b0}};
						for (int i = 0; i < {req[4], req[5]}; i++) begin
							c = {req[2], req[3]} + 16'(i);
							rsp.push_back(c[15:8]);
							rsp.push_back(c[7:0]);
						end
					end
					c = crc16(rsp);
					rsp.push_back(c[7:0]);
					rsp.push_back(c[15:8]);
				end
				req.delete();
				repeat (8 * HC) @(negedge core_clk_in);
				foreach (rsp[i]) begin
					repeat ((fault_in == 2'd2 && i == 3) ? 5 * HC : HC) @(negedge core_clk_in);
					rx_byte_out = rsp[i];
					rx_valid_out = 1'b1;
					@(negedge core_clk_in);
					rx_valid_out = 1'b0;
					rx_byte_out = ~rsp[i];
				end
			end
		end
	end
endmodule : modbus_slave_model
`default_nettype wire
